// [design/sync_ctl_pkg.sv]
// Purpose: shared constants and types of the sync status, hold and clamp block
// Assumes: 40 MHz pclk, byte registers behind a 32-bit APB slave
// Notes: byte address of each register is four times its index
package sync_ctl_pkg;
    // clock rate and activity window
    localparam int CLK_MHZ = 40;
    localparam int ACT_WINDOW_US = 100_000;
    localparam int unsigned ACT_CYCLES_DFLT = ACT_WINDOW_US * CLK_MHZ;
    localparam int ACT_W = 22;
    // detector widths
    localparam int N_IN = 7;
    localparam int POL_W = 16;
    localparam int PER_W = 16;
    localparam int LPF_W = 12;
    localparam logic [PER_W-1:0] SYNC_TOL = 16'h000a;
    localparam logic [LPF_W-1:0] LPF_MAX = 12'hfff;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic signed [POL_W-1:0] POL_MAX = 16'sh7fff;
    localparam logic signed [POL_W-1:0] POL_MIN = -16'sh7fff;
    // input positions inside the pin struct
    localparam int X_LINE0 = 6;
    localparam int X_LINE1 = 5;
    localparam int X_FLD0 = 4;
    localparam int X_FLD1 = 3;
    localparam int X_HOLD = 0;
    // register indices
    localparam logic [7:0] I_SRC_SEL = 8'h11;
    localparam logic [7:0] I_HOLD_CTL = 8'h12;
    localparam logic [7:0] I_LEAD = 8'h13;
    localparam logic [7:0] I_TRAIL = 8'h14;
    localparam logic [7:0] I_ACT_STAT = 8'h15;
    localparam logic [7:0] I_POL_STAT = 8'h16;
    localparam logic [7:0] I_LPF_HI = 8'h17;
    localparam logic [7:0] I_LPF_LO = 8'h18;
    localparam logic [7:0] I_CLAMP_DLY = 8'h19;
    localparam logic [7:0] I_CLAMP_LEN = 8'h1a;
    localparam logic [7:0] I_CLAMP_SEL = 8'h1b;
    localparam logic [7:0] I_LOCK_TH = 8'h1e;
    localparam logic [7:0] I_UNLOCK_TH = 8'h1f;
    // bit positions
    localparam int B_FPOL_MAN = 5;
    localparam int B_CHAN = 3;
    localparam int B_FPOL_OVR = 4;
    localparam int B_HPOL = 3;
    localparam int B_HPOL_OVR = 2;
    localparam int B_HSRC = 1;
    localparam int B_HFILT = 0;
    localparam int B_RED = 7;
    localparam int B_GRN = 6;
    localparam int B_LOCK = 1;
    // reset values and writable masks
    localparam logic [7:0] RST_SRC_SEL = 8'h00;
    localparam logic [7:0] RST_HOLD_CTL = 8'h09;
    localparam logic [7:0] RST_LINES = 8'h00;
    localparam logic [7:0] RST_CLAMP_DLY = 8'h08;
    localparam logic [7:0] RST_CLAMP_LEN = 8'h14;
    localparam logic [7:0] RST_CLAMP_SEL = 8'h00;
    localparam logic [7:0] RST_LOCK_TH = 8'h20;
    localparam logic [7:0] RST_UNLOCK_TH = 8'h32;
    localparam logic [7:0] M_SRC_SEL = 8'h28;
    localparam logic [7:0] M_HOLD_CTL = 8'h1f;
    localparam logic [7:0] M_CLAMP_SEL = 8'hc0;
    // sync pins, first field is the top bit
    typedef struct packed {
        logic line_sync_in_0;
        logic line_sync_in_1;
        logic field_sync_in_0;
        logic field_sync_in_1;
        logic green_embedded_sync_0;
        logic green_embedded_sync_1;
        logic external_hold_in;
    } sync_pins_s;
    // clamp sequencer
    typedef enum logic [1:0] {
        CL_IDLE = 2'b00,
        CL_WAIT = 2'b01,
        CL_ON = 2'b11
    } clamp_state_e;
endpackage

// [design/sync_status_hold_clamp_ctrl.sv]
// Purpose: sync status, hold window and clamp control registers over APB
// Assumes: pins are asynchronous to pclk, one register per aligned word
// Notes: status bits carry no storage and follow the detectors
//
// Overview of operation
// - field polarity override picks manual polarity
// - hold polarity bit: 0 low, 1 high
// - hold polarity override picks programmed polarity
// - hold source: internal window or external pin
// - internal window uses raw or filtered field
// - window opens lead lines before field sync
// - window stays trail lines after field sync
// - activity bits for line, field, green syncs
// - activity bit for shared external hold pin
// - detected polarity of line and field syncs
// - detected polarity of external hold input
// - lock status bit reads zero when locked
// - twelve bit lines per field count
// - clamp starts delay clocks after line trail
// - clamp lasts the programmed number of clocks
// - red clamp level ground or midscale
// - green clamp level ground or midscale
// - lock after good syncs, unlock after bad
`timescale 1ns/1ps
`default_nettype none
module sync_status_hold_clamp_ctrl
    import sync_ctl_pkg::*;
#(
    parameter int unsigned ACT_CYCLES = ACT_CYCLES_DFLT
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // sync pins
    input wire sync_pins_s pins,
    // front-end controls
    output logic hold_window,
    output logic clamp_pulse,
    output logic clamp_red_mid,
    output logic clamp_green_mid
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers and edges

logic [N_IN-1:0] s1_r; // first stage, read only by s2
logic [N_IN-1:0] s2_r;
logic [N_IN-1:0] s3_r;
logic [N_IN-1:0] cln_r; // accepted level
logic [N_IN-1:0] prv_r; // last accepted level
wire logic [N_IN-1:0] agree = ~(s2_r ^ s3_r);
wire logic [N_IN-1:0] cln_nxt = (agree & s3_r) | (~agree & cln_r);
wire logic [N_IN-1:0] edg = cln_r ^ prv_r;

// a change counts only once stages two and three agree
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        s1_r <= '0;
        s2_r <= '0;
        s3_r <= '0;
        cln_r <= '0;
        prv_r <= '0;
    end else if (clk_en) begin
        s1_r <= pins;
        s2_r <= s1_r;
        s3_r <= s2_r;
        cln_r <= cln_nxt;
        prv_r <= cln_r;
    end
end

////////////////////////////////////////////////////////////////////////////////
// activity and polarity detectors, one per input

logic [N_IN-1:0] act_w; // any edge inside the window
logic [N_IN-1:0] pol_w; // 1 when pulses are high

for (genvar i = 0; i < N_IN; i++) begin : g_det
    logic [ACT_W-1:0] tmo_r; // cycles left before idle
    logic signed [POL_W-1:0] acc_r; // high minus low time
    // a dc level lets the window run out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmo_r <= '0;
        end else if (clk_en && edg[i]) begin
            tmo_r <= ACT_W'(ACT_CYCLES);
        end else if (clk_en && tmo_r != '0) begin
            tmo_r <= tmo_r - 1'b1;
        end
    end
    // saturating balance, short pulses win the sign
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_r <= '0;
        end else if (clk_en && cln_r[i] && acc_r != POL_MAX) begin
            acc_r <= acc_r + 1'b1;
        end else if (clk_en && !cln_r[i] && acc_r != POL_MIN) begin
            acc_r <= acc_r - 1'b1;
        end
    end
    assign act_w[i] = |tmo_r;
    assign pol_w[i] = acc_r[POL_W-1];
end

////////////////////////////////////////////////////////////////////////////////
// registers and apb decode

logic [7:0] src_sel_r; // manual field polarity, channel
logic [7:0] hold_ctl_r; // polarity and hold source
logic [7:0] lead_r; // lines before field sync
logic [7:0] trail_r; // lines after field sync
logic [7:0] cdly_r; // clamp start delay
logic [7:0] clen_r; // clamp length
logic [7:0] csel_r; // clamp levels
logic [7:0] lock_th_r;
logic [7:0] unlock_th_r;
logic locked_r;
logic [LPF_W-1:0] lpf_r;
logic [31:0] prdata_r;
logic pready_r;
logic pslverr_r;

wire logic s_src = paddr == 8'(I_SRC_SEL * 4);
wire logic s_hctl = paddr == 8'(I_HOLD_CTL * 4);
wire logic s_lead = paddr == 8'(I_LEAD * 4);
wire logic s_trail = paddr == 8'(I_TRAIL * 4);
wire logic s_act = paddr == 8'(I_ACT_STAT * 4);
wire logic s_pol = paddr == 8'(I_POL_STAT * 4);
wire logic s_lhi = paddr == 8'(I_LPF_HI * 4);
wire logic s_llo = paddr == 8'(I_LPF_LO * 4);
wire logic s_cdly = paddr == 8'(I_CLAMP_DLY * 4);
wire logic s_clen = paddr == 8'(I_CLAMP_LEN * 4);
wire logic s_csel = paddr == 8'(I_CLAMP_SEL * 4);
wire logic s_lth = paddr == 8'(I_LOCK_TH * 4);
wire logic s_uth = paddr == 8'(I_UNLOCK_TH * 4);
wire logic hit = s_src | s_hctl | s_lead | s_trail | s_act | s_pol | s_lhi
    | s_llo | s_cdly | s_clen | s_csel | s_lth | s_uth;
// status words are built live from the detectors
wire logic [7:0] act_stat = {act_w, 1'b0};
wire logic [7:0] pol_stat = {pol_w[X_LINE0:X_FLD1], pol_w[X_HOLD], 1'b0,
    ~locked_r, 1'b0};
wire logic [7:0] rd_byte = ({8{s_src}} & src_sel_r) | ({8{s_hctl}} & hold_ctl_r)
    | ({8{s_lead}} & lead_r) | ({8{s_trail}} & trail_r)
    | ({8{s_act}} & act_stat) | ({8{s_pol}} & pol_stat)
    | ({8{s_lhi}} & {4'h0, lpf_r[LPF_W-1:8]})
    | ({8{s_llo}} & lpf_r[7:0]) | ({8{s_cdly}} & cdly_r)
    | ({8{s_clen}} & clen_r) | ({8{s_csel}} & csel_r)
    | ({8{s_lth}} & lock_th_r) | ({8{s_uth}} & unlock_th_r);
// writes land at the access edge, low byte lane only
wire logic wr = psel & penable & pready_r & pwrite & pstrb[0] & clk_en;
wire logic [7:0] wb = pwdata[7:0];

// one wait-free access phase; read data is caught in setup
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready_r <= 1'b0;
        pslverr_r <= 1'b0;
        prdata_r <= '0;
    end else if (clk_en) begin
        pready_r <= psel & ~penable;
        pslverr_r <= psel & ~penable & ~hit;
        prdata_r <= {24'h00_0000, rd_byte};
    end
end

// control registers; status addresses take no write
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        src_sel_r <= RST_SRC_SEL;
        hold_ctl_r <= RST_HOLD_CTL;
        lead_r <= RST_LINES;
        trail_r <= RST_LINES;
        cdly_r <= RST_CLAMP_DLY;
        clen_r <= RST_CLAMP_LEN;
        csel_r <= RST_CLAMP_SEL;
        lock_th_r <= RST_LOCK_TH;
        unlock_th_r <= RST_UNLOCK_TH;
    end else if (wr) begin
        if (s_src) src_sel_r <= wb & M_SRC_SEL;
        if (s_hctl) hold_ctl_r <= wb & M_HOLD_CTL;
        if (s_lead) lead_r <= wb;
        if (s_trail) trail_r <= wb;
        if (s_cdly) cdly_r <= wb;
        if (s_clen) clen_r <= wb;
        if (s_csel) csel_r <= wb & M_CLAMP_SEL;
        if (s_lth) lock_th_r <= wb;
        if (s_uth) unlock_th_r <= wb;
    end
end

////////////////////////////////////////////////////////////////////////////////
// active input, polarity normalisation

wire logic chan = src_sel_r[B_CHAN];
wire logic line_raw = chan ? cln_r[X_LINE1] : cln_r[X_LINE0];
wire logic line_pol = chan ? pol_w[X_LINE1] : pol_w[X_LINE0];
wire logic line_n = line_pol ? line_raw : ~line_raw;
wire logic fld_raw = chan ? cln_r[X_FLD1] : cln_r[X_FLD0];
wire logic fld_det = chan ? pol_w[X_FLD1] : pol_w[X_FLD0];
wire logic fld_pol = hold_ctl_r[B_FPOL_OVR] ? src_sel_r[B_FPOL_MAN] : fld_det;
wire logic fld_n = fld_pol ? fld_raw : ~fld_raw;
// no override: follow the detected hold polarity
wire logic hpol = hold_ctl_r[B_HPOL_OVR] ? hold_ctl_r[B_HPOL] : pol_w[X_HOLD];
wire logic ext_hold = hpol ? cln_r[X_HOLD] : ~cln_r[X_HOLD];

logic line_prv_r;
logic fs_prv_r;
logic vfilt_r; // field level resampled on line edges
wire logic line_lead = line_n & ~line_prv_r;
wire logic line_trail = ~line_n & line_prv_r;
wire logic fsrc = hold_ctl_r[B_HFILT] ? vfilt_r : fld_n;
wire logic fs_lead = fsrc & ~fs_prv_r;
wire logic fs_trail = ~fsrc & fs_prv_r;

// filtered field only moves on a line edge, so stray pulses vanish
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        line_prv_r <= 1'b0;
        fs_prv_r <= 1'b0;
        vfilt_r <= 1'b0;
    end else if (clk_en) begin
        line_prv_r <= line_n;
        fs_prv_r <= fsrc;
        if (line_lead) vfilt_r <= fld_n;
    end
end

////////////////////////////////////////////////////////////////////////////////
// sync filter lock

logic [PER_W-1:0] per_r; // cycles since last line edge
logic [PER_W-1:0] lastper_r;
logic [7:0] good_r;
logic [7:0] bad_r;
wire logic [PER_W-1:0] diff = per_r > lastper_r ? per_r - lastper_r : lastper_r - per_r;
wire logic valid = line_lead & (diff <= SYNC_TOL);
// no edge by twice the last period counts as a missing sync
wire logic missing = ~line_lead & (lastper_r != '0)
    & (per_r == {lastper_r[PER_W-2:0], 1'b0});
wire logic bad_evt = (line_lead & ~valid) | missing;

always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        per_r <= '0;
        lastper_r <= '0;
    end else if (clk_en) begin
        if (line_lead) lastper_r <= per_r;
        if (line_lead || missing) per_r <= '0;
        else if (per_r != '1) per_r <= per_r + 1'b1;
    end
end

// good and bad runs drive lock and unlock
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        good_r <= '0;
        bad_r <= '0;
        locked_r <= 1'b0;
    end else if (clk_en) begin
        if (valid) begin
            good_r <= good_r == CNT_MAX ? good_r : good_r + 1'b1;
            bad_r <= '0;
        end else if (bad_evt) begin
            good_r <= '0;
            bad_r <= bad_r == CNT_MAX ? bad_r : bad_r + 1'b1;
        end
        if (!locked_r && good_r >= lock_th_r) locked_r <= 1'b1;
        else if (locked_r && bad_r >= unlock_th_r) locked_r <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// lines per field and internal hold window

logic [LPF_W-1:0] ln_cnt_r; // lines since field lead
logic [7:0] post_r; // trail lines still to hold
wire logic pre_on = (lead_r != '0) & (lpf_r != '0)
    & (({1'b0, ln_cnt_r} + 13'(lead_r)) >= {1'b0, lpf_r});
// trail term bridges the one cycle before post_r is loaded
wire logic int_hold = pre_on | fsrc | (fs_trail & (trail_r != '0)) | (post_r != '0);
wire logic hold_nxt = hold_ctl_r[B_HSRC] ? ext_hold : int_hold;

// count latched at each field lead, saturates at all ones
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ln_cnt_r <= '0;
        lpf_r <= '0;
        post_r <= '0;
        hold_window <= 1'b0;
    end else if (clk_en) begin
        if (fs_lead) begin
            lpf_r <= ln_cnt_r;
            ln_cnt_r <= '0;
        end else if (line_lead && ln_cnt_r != LPF_MAX) begin
            ln_cnt_r <= ln_cnt_r + 1'b1;
        end
        if (fs_trail) post_r <= trail_r;
        else if (line_lead && post_r != '0) post_r <= post_r - 1'b1;
        hold_window <= hold_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// clamp sequencer

clamp_state_e cl_st_r;
clamp_state_e cl_st_nxt;
logic [7:0] cl_cnt_r;
logic [7:0] cl_cnt_nxt;

// a new trailing edge mid-clamp is ignored until idle
always_comb begin
    cl_st_nxt = cl_st_r;
    cl_cnt_nxt = cl_cnt_r;
    unique case (cl_st_r)
        CL_IDLE: begin
            if (line_trail && cdly_r != '0) begin
                cl_st_nxt = CL_WAIT;
                cl_cnt_nxt = cdly_r;
            end else if (line_trail && clen_r != '0) begin
                cl_st_nxt = CL_ON;
                cl_cnt_nxt = clen_r;
            end
        end
        CL_WAIT: begin
            cl_cnt_nxt = cl_cnt_r - 1'b1;
            if (cl_cnt_r == 8'h01) begin
                cl_st_nxt = clen_r != '0 ? CL_ON : CL_IDLE;
                cl_cnt_nxt = clen_r;
            end
        end
        CL_ON: begin
            cl_cnt_nxt = cl_cnt_r - 1'b1;
            if (cl_cnt_r == 8'h01) cl_st_nxt = CL_IDLE;
        end
        default: begin
            cl_st_nxt = CL_IDLE;
            cl_cnt_nxt = '0;
        end
    endcase
end

always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cl_st_r <= CL_IDLE;
        cl_cnt_r <= '0;
        clamp_pulse <= 1'b0;
    end else if (clk_en) begin
        cl_st_r <= cl_st_nxt;
        cl_cnt_r <= cl_cnt_nxt;
        clamp_pulse <= cl_st_nxt == CL_ON;
    end
end

// outputs straight from flops
assign prdata = prdata_r;
assign pready = pready_r;
assign pslverr = pslverr_r;
assign clamp_red_mid = csel_r[B_RED];
assign clamp_green_mid = csel_r[B_GRN];

////////////////////////////////////////////////////////////////////////////////
// assertions

fld_pol_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && hold_ctl_r[B_FPOL_OVR] |=> fs_prv_r == $past(hold_ctl_r[B_HFILT]
        ? vfilt_r : (src_sel_r[B_FPOL_MAN] ? fld_raw : ~fld_raw)))
    else $error("manual field polarity not applied");
hold_rst_a: assert property (
    @(posedge pclk) $rose(presetn) |-> hold_ctl_r == RST_HOLD_CTL)
    else $error("hold control reset value wrong");
ext_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && hold_ctl_r[B_HSRC] |=> hold_window == $past((hold_ctl_r[B_HPOL_OVR]
        ? hold_ctl_r[B_HPOL] : pol_stat[3]) ~^ cln_r[X_HOLD]))
    else $error("external hold polarity wrong");
pre_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && !hold_ctl_r[B_HSRC] && pre_on |=> hold_window)
    else $error("lead lines did not open hold");
post_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && fs_trail && trail_r != '0 && !hold_ctl_r[B_HSRC] |=> hold_window)
    else $error("trail lines did not extend hold");
act_seen_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && edg[X_HOLD] |=> act_stat[1] [*2])
    else $error("activity not flagged after edge");
lock_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && psel && !penable && s_pol |=> prdata[B_LOCK] == !$past(locked_r))
    else $error("lock status sense wrong");
lpf_latch_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && fs_lead |=> lpf_r == $past(ln_cnt_r) && ln_cnt_r == '0)
    else $error("lines per field not latched");
clamp_wait_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && cl_st_r == CL_IDLE && line_trail && cdly_r != '0
        |=> cl_st_r == CL_WAIT && cl_cnt_r == $past(cdly_r) && !clamp_pulse)
    else $error("clamp delay not started");
clamp_len_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && cl_st_r == CL_WAIT && cl_cnt_r == 8'h01 && clen_r != '0
        |=> clamp_pulse && cl_cnt_r == $past(clen_r))
    else $error("clamp length not loaded");
clamp_lvl_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && s_csel |=> clamp_red_mid == $past(pwdata[B_RED])
        && clamp_green_mid == $past(pwdata[B_GRN]))
    else $error("clamp level select not written");
lock_gain_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && !locked_r && good_r >= lock_th_r |=> locked_r)
    else $error("lock not reached at threshold");
lock_seen_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(locked_r));
clamp_seen_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(clamp_pulse));
hold_seen_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(hold_window));

endmodule
`default_nettype wire

// [verification/sync_source_model.sv]
// Purpose: video source model driving the sync pins
// Assumes: line period LP clocks, field pulse every NL lines
// Notes: line set 1 is active low, green set 1 held dc
`timescale 1ns/1ps
`default_nettype none
module sync_source_model
    import sync_ctl_pkg::*;
#(
    parameter int LP = 40,
    parameter int NL = 20
) (
    // clock and controls
    input wire logic pclk,
    input wire logic run,
    input wire logic hold_lvl,
    // pins toward the block
    output sync_pins_s pins
);
    int pos = 0; // clock within line
    int line = 0; // line within field
    // idle levels before the first edge
    initial pins = 7'h22;
    ////////////////////////////////////////////////////////////////////////////
    // counters freeze when stopped, so every sync pin goes dc; the hold pin keeps following hold_lvl
    always @(posedge pclk) begin
        if (run) begin
            pos <= (pos == LP - 1) ? 0 : pos + 1;
            if (pos == LP - 1) line <= (line == NL - 1) ? 0 : line + 1;
        end
    end
    // short high pulse keeps set 0 positive
    always @(posedge pclk) begin
        pins.line_sync_in_0 <= run && pos < 4;
        pins.line_sync_in_1 <= !(run && pos < 4);
        pins.field_sync_in_0 <= run && line == 0;
        pins.field_sync_in_1 <= 1'b0;
        pins.green_embedded_sync_0 <= run && pos < 4;
        pins.green_embedded_sync_1 <= 1'b1;
        pins.external_hold_in <= hold_lvl;
    end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Purpose: self-checking bench of the sync status, hold and clamp block
// Assumes: apb master, short activity window in sim
// Notes: expected register image kept in exp_r
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sync_ctl_pkg::*;
    localparam int ACT = 2000; // shortened activity window
    logic pclk = 0;
    logic presetn = 0;
    logic clk_en = 1;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, hold_window, clamp_pulse, red_mid, grn_mid, err;
    logic run = 0, hold_lvl = 0, ls_q = 0, cp_q = 0;
    sync_pins_s pins;
    int miscompares = 0, compares = 0;
    int tcnt = 0, run_len = 0, last_len = 0, rise_dly = 0, d, l, r0;
    logic [7:0] exp_r [0:31]; // expected register image
    logic [7:0] rwl [9] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h19, 8'h1a, 8'h1b, 8'h1e, 8'h1f};
    logic [7:0] rst [9] = '{8'h00, 8'h09, 8'h00, 8'h00, 8'h08, 8'h14, 8'h00, 8'h20, 8'h32};
    logic [7:0] bad [4] = '{8'h00, 8'h4a, 8'h80, 8'hfc}; // unmapped or misaligned
    sync_status_hold_clamp_ctrl #(.ACT_CYCLES(ACT)) u_dut (.pclk(pclk), .presetn(presetn),
        .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pins(pins), .hold_window(hold_window), .clamp_pulse(clamp_pulse),
        .clamp_red_mid(red_mid), .clamp_green_mid(grn_mid));
    sync_source_model u_src (.pclk(pclk), .run(run), .hold_lvl(hold_lvl), .pins(pins));
    always #12.5 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////////
    // clamp timing from line trailing edge, and pulse length
    always @(posedge pclk) begin
        ls_q <= pins.line_sync_in_0;
        cp_q <= clamp_pulse;
        tcnt <= (ls_q && !pins.line_sync_in_0) ? 0 : tcnt + 1;
        run_len <= clamp_pulse ? run_len + 1 : 0;
        if (clamp_pulse && !cp_q) rise_dly <= tcnt;
        if (!clamp_pulse && cp_q) last_len <= run_len;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic [7:0] msk(input logic [7:0] i);
        case (i)
            8'h11: return 8'h28;
            8'h12: return 8'h1f;
            8'h1b: return 8'hc0;
            8'h13, 8'h14, 8'h19, 8'h1a, 8'h1e, 8'h1f: return 8'hff;
            default: return 8'h00; // read-only or unmapped
        endcase
    endfunction
    // one transfer, request held until pready sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] v,
            input logic [3:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, v};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        if (n >= 50) miscompares++;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] v, input logic [3:0] s);
        apb(1, {i[5:0], 2'b00}, v, s);
        if (s[0]) exp_r[i[4:0]] = (v & msk(i)) | (exp_r[i[4:0]] & ~msk(i));
    endtask
    task automatic rc(input string nm, input logic [7:0] i, input logic [7:0] m,
            input logic [7:0] e);
        apb(0, {i[5:0], 2'b00}, 8'h00, 4'h0);
        chk(nm, rd & {24'hff_ffff, m}, {24'h00_0000, e & m});
        chk("slverr", {31'h0, err}, 32'h0);
    endtask
    // hold pin level, then window after latency
    task automatic hc(input logic lvl, input logic e);
        hold_lvl <= lvl;
        repeat (12) @(posedge pclk);
        chk("hold", {31'h0, hold_window}, {31'h0, e});
    endtask
    task automatic test_done;
        if (miscompares == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        exp_r = '{default: 8'h00};
        foreach (rwl[i]) exp_r[rwl[i][4:0]] = rst[i];
        repeat (8) @(posedge pclk);
        presetn <= 1;
        void'($urandom(85851));
        foreach (rwl[i]) rc("reset", rwl[i], 8'hff, exp_r[rwl[i][4:0]]);
        rc("lock_rst", 8'h16, 8'h02, 8'h02);
        foreach (rwl[i]) begin
            wr(rwl[i], 8'($urandom), 4'hf);
            rc("rw", rwl[i], 8'hff, exp_r[rwl[i][4:0]]);
            wr(rwl[i], 8'($urandom), 4'he);
            rc("strb", rwl[i], 8'hff, exp_r[rwl[i][4:0]]);
        end
        for (int k = 0; k < 4; k++) begin
            wr(8'h1b, 8'(k << 6), 4'hf);
            @(posedge pclk);
            chk("red", {31'h0, red_mid}, {31'h0, k[1]});
            chk("grn", {31'h0, grn_mid}, {31'h0, k[0]});
        end
        foreach (bad[i]) begin
            apb(0, bad[i], 8'h00, 4'h0);
            chk("err", {31'h0, err}, 32'h1);
            chk("rd0", rd, 32'h0);
        end
        // defaults back; hold filter stays matched with the line filter
        foreach (rwl[i]) wr(rwl[i], rst[i], 4'hf);
        run <= 1;
        repeat (2400) @(posedge pclk);
        rc("act", 8'h15, 8'hfe, 8'he8);
        rc("pol", 8'h16, 8'hfa, 8'hb8);
        rc("lpf_hi", 8'h17, 8'h0f, 8'h00);
        rc("lpf_lo", 8'h18, 8'hff, 8'd20);
        chk("clamp_len", 32'(last_len), 32'd20);
        wr(8'h19, 8'h00, 4'hf);
        repeat (100) @(posedge pclk);
        r0 = rise_dly;
        d = $urandom_range(1, 15);
        l = $urandom_range(1, 16);
        wr(8'h19, 8'(d), 4'hf);
        wr(8'h1a, 8'(l), 4'hf);
        repeat (100) @(posedge pclk);
        chk("clamp_dly", 32'(rise_dly - r0), 32'(d));
        chk("clamp_len", 32'(last_len), 32'(l));
        wr(8'h1a, 8'h00, 4'hf);
        repeat (40) @(posedge pclk);
        d = 0;
        repeat (80) begin
            @(posedge pclk);
            if (clamp_pulse !== 1'b0) d++;
        end
        chk("clamp_off", 32'(d), 32'h0);
        // internal window: lead, field and trail lines, one field counted
        d = $urandom_range(1, 5);
        l = $urandom_range(1, 5);
        wr(8'h13, 8'(d), 4'hf);
        wr(8'h14, 8'(l), 4'hf);
        repeat (1700) @(posedge pclk);
        r0 = 0;
        repeat (800) begin
            @(posedge pclk);
            if (hold_window === 1'b1) r0++;
        end
        chk("hold_int", 32'(r0), 32'(40 * (d + 1 + l)));
        wr(8'h12, 8'h0f, 4'hf);
        hc(1, 1);
        hc(0, 0);
        wr(8'h12, 8'h07, 4'hf);
        hc(0, 1);
        hc(1, 0);
        rc("act_hold", 8'h15, 8'hfe, 8'hea);
        wr(8'h12, 8'h03, 4'hf);
        hc(1, 1);
        hc(0, 0);
        // enable low freezes the hold path
        clk_en <= 0;
        hc(1, 0);
        clk_en <= 1;
        hc(1, 1);
        run <= 0;
        repeat (ACT + 100) @(posedge pclk);
        rc("act_off", 8'h15, 8'hfe, 8'h00);
        wr(8'h15, 8'hff, 4'hf);
        rc("act_ro", 8'h15, 8'hfe, 8'h00);
        test_done();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        test_done();
    end
endmodule
`default_nettype wire
